// ### core/flash_prot_pkg.sv
package flash_prot_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 24;
    localparam int LOCK_N = 286;
    localparam int PAGE_SH = 8;
    localparam int SECTOR_SH = 12;
    localparam int BLK32_SH = 15;
    localparam int BLK64_SH = 16;
    localparam logic [8:0] TOP_LOCK_BASE = 9'h010;
    localparam logic [8:0] MID_LOCK_OFS = 9'h01f;
    localparam logic [7:0] BOTTOM_BLOCK = 8'h00;
    localparam logic [7:0] TOP_BLOCK = 8'hff;

    // ------------------------------------------------------------
    // Protect field decode (shift = log2 of protected size)
    // ------------------------------------------------------------
    localparam logic [4:0] BP_BIG_BASE = 5'h11;
    localparam logic [4:0] BP_SMALL_BASE = 5'h0b;
    localparam logic [4:0] BP_SMALL_MAX = 5'h0f;
    localparam logic [2:0] BP_NONE = 3'h0;
    localparam logic [2:0] BP_ALL = 3'h7;
    localparam logic [2:0] BP_SMALL_CAP = 3'h4;

    // ------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_WRSR = 8'h01;
    localparam logic [7:0] OP_PP = 8'h02;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_WRITE_ENABLE_COMMAND = 8'h06;
    localparam logic [7:0] OP_SE = 8'h20;
    localparam logic [7:0] OP_BE32 = 8'h52;
    localparam logic [7:0] OP_BE64 = 8'hd8;
    localparam logic [7:0] OP_CE1 = 8'h60;
    localparam logic [7:0] OP_CE2 = 8'hc7;
    localparam logic [7:0] OP_LOCK = 8'h36;
    localparam logic [7:0] OP_UNLOCK = 8'h39;
    localparam logic [7:0] OP_RDLOCK = 8'h3c;
    localparam logic [7:0] OP_GLOCK = 8'h7e;
    localparam logic [7:0] OP_GUNLOCK = 8'h98;
    localparam logic [7:0] OP_DPD = 8'hb9;
    localparam logic [7:0] OP_RDPD = 8'hab;

    // ------------------------------------------------------------
    // Register map, field positions, reset values
    // ------------------------------------------------------------
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_CTRL = 8'h04;
    localparam logic [7:0] REG_VERDICT = 8'h08;
    localparam logic [7:0] REG_OP_ADDR = 8'h0c;
    localparam logic [7:0] REG_FILL = 8'h10;
    localparam int ST_WEL_BIT = 1;
    localparam int ST_BP_LSB = 2;
    localparam int ST_SRP0_BIT = 7;
    localparam int ST_SRP1_BIT = 8;
    localparam int ST_WPS_BIT = 10;
    localparam int ST_CMP_BIT = 14;
    localparam int ST_DPD_BIT = 16;
    localparam logic [15:0] STATUS_RST = 16'h0000;
    localparam logic [31:0] CTRL_RST = 32'h0000_0001;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [3:0] PIN_IDLE = 4'ha;

    typedef enum logic [2:0] {
        ST_STANDBY = 3'b001,
        ST_FRAME = 3'b010,
        ST_EXEC = 3'b100
    } ctl_state_t;

endpackage

// ### core/flash_write_protect.sv
// Behaviour
// - Erased array bytes read as all ones
// - Status bits all zero after reset
// - Control machine starts in standby
// - Execute only byte-aligned, complete commands
// - Data-changing commands need write enable latch
// - Protect field selects unwritable array region
// - Pin low freezes protect and status-protect bits
// - Deep power-down ignores all but release
// - Coarse codes protect 256KB to 8MB
// - Fine codes protect 4KB to 32KB
// - Complement inverts the protected range
// - Erase/program touching protection is dropped
// - Lock bits apply only in lock mode
// - All lock bits set after reset
// - 32 sector locks plus 254 block locks
// - Lock, unlock, read lock by address
// - Decode pages, sectors, blocks and chip
// - Chip select must rise on byte boundary
`timescale 1ns/1ps
module flash_write_protect (
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial link pins
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic si,
    input wire logic wp_n,
    output logic so_o,
    output logic so_oe,
    // Array operation verdict
    output logic grant,
    output logic reject,
    output logic [7:0] op_code,
    output logic [flash_prot_pkg::ADDR_W-1:0] op_addr
);
    import flash_prot_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [3:0] pins;
    logic [3:0] s1_reg, s2_reg, s3_reg, clean_reg;
    assign pins = {wp_n, si, cs_n, sclk};

    // Three stages; a level counts once stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_reg <= PIN_IDLE;
            s2_reg <= PIN_IDLE;
            s3_reg <= PIN_IDLE;
        end else begin
            s1_reg <= pins;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_filt
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    clean_reg[g] <= PIN_IDLE[g];
                end else if (s2_reg[g] == s3_reg[g]) begin
                    clean_reg[g] <= s3_reg[g];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Edge detection and frame control
    // ------------------------------------------------------------
    logic [31:0] ctrl_reg;
    logic sclk_prev_reg, cs_prev_reg;
    logic cs_act, sclk_rise, cs_fall, cs_rise, wp_lvl;
    ctl_state_t state_reg, state_next;

    assign cs_act = ~clean_reg[1] & ctrl_reg[0];
    assign sclk_rise = clean_reg[0] & ~sclk_prev_reg;
    assign cs_fall = cs_act & ~cs_prev_reg;
    assign cs_rise = ~cs_act & cs_prev_reg;
    assign wp_lvl = clean_reg[3];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_prev_reg <= 1'b0;
            cs_prev_reg <= 1'b0;
            state_reg <= ST_STANDBY;
        end else begin
            sclk_prev_reg <= clean_reg[0];
            cs_prev_reg <= cs_act;
            state_reg <= state_next;
        end
    end

    // Standby until select, frame until deselect, one execute cycle
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_STANDBY: if (cs_fall) state_next = ST_FRAME;
            ST_FRAME: if (cs_rise) state_next = ST_EXEC;
            ST_EXEC: state_next = ST_STANDBY;
            default: state_next = ST_STANDBY;
        endcase
    end

    // ------------------------------------------------------------
    // Byte shifter
    // ------------------------------------------------------------
    logic [6:0] shift_reg;
    logic [2:0] bit_cnt_reg, byte_cnt_reg;
    logic [7:0] opc_reg, st0_reg, st1_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic shifting, byte_done;
    logic [7:0] byte_w;

    assign shifting = (state_reg == ST_FRAME) & cs_act & sclk_rise;
    assign byte_done = shifting & (bit_cnt_reg == 3'h7);
    assign byte_w = {shift_reg, clean_reg[2]};

    // Bits enter on sclk rising edges, first byte is the command
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_reg <= 7'h00;
            bit_cnt_reg <= 3'h0;
            byte_cnt_reg <= 3'h0;
            opc_reg <= 8'h00;
            st0_reg <= 8'h00;
            st1_reg <= 8'h00;
            addr_reg <= '0;
        end else if (cs_fall) begin
            bit_cnt_reg <= 3'h0;
            byte_cnt_reg <= 3'h0;
            opc_reg <= 8'h00; // Stale command never runs again
        end else if (shifting) begin
            shift_reg <= byte_w[6:0];
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (byte_done) begin
                if (byte_cnt_reg != 3'h7) byte_cnt_reg <= byte_cnt_reg + 3'h1;
                if (byte_cnt_reg == 3'h0) opc_reg <= byte_w;
                if (byte_cnt_reg == 3'h1) st0_reg <= byte_w;
                if (byte_cnt_reg == 3'h2) st1_reg <= byte_w;
                if (byte_cnt_reg == 3'h1) addr_reg[23:16] <= byte_w;
                if (byte_cnt_reg == 3'h2) addr_reg[15:8] <= byte_w;
                if (byte_cnt_reg == 3'h3) addr_reg[7:0] <= byte_w;
            end
        end
    end

    // ------------------------------------------------------------
    // Command qualification
    // ------------------------------------------------------------
    logic exec, is_ce, is_ep, is_wcls, len_ok, frame_ok, exec_ok, wel_ok;
    logic wel_reg, dpd_reg, do_write;
    logic is_one, is_four;

    assign exec = (state_reg == ST_EXEC);
    assign is_ce = (opc_reg == OP_CE1) | (opc_reg == OP_CE2);
    assign is_ep = is_ce | (opc_reg == OP_PP) | (opc_reg == OP_SE)
                 | (opc_reg == OP_BE32) | (opc_reg == OP_BE64);
    assign is_wcls = is_ep | (opc_reg == OP_WRSR) | (opc_reg == OP_LOCK)
                   | (opc_reg == OP_UNLOCK) | (opc_reg == OP_GLOCK)
                   | (opc_reg == OP_GUNLOCK);
    assign is_one = is_ce | (opc_reg == OP_WRITE_ENABLE_COMMAND) | (opc_reg == OP_WRDI)
                  | (opc_reg == OP_DPD) | (opc_reg == OP_RDPD)
                  | (opc_reg == OP_GLOCK) | (opc_reg == OP_GUNLOCK);
    assign is_four = (opc_reg == OP_SE) | (opc_reg == OP_BE32)
                   | (opc_reg == OP_BE64) | (opc_reg == OP_LOCK)
                   | (opc_reg == OP_UNLOCK);
    // Exact byte counts per command, except program: five bytes or more, so at least one data byte
    assign len_ok = (is_one & (byte_cnt_reg == 3'h1))
                  | (is_four & (byte_cnt_reg == 3'h4))
                  | ((opc_reg == OP_WRSR) & (byte_cnt_reg == 3'h3))
                  | ((opc_reg == OP_PP) & (byte_cnt_reg >= 3'h5));
    assign frame_ok = (bit_cnt_reg == 3'h0);
    assign exec_ok = exec & frame_ok & len_ok
                   & (~dpd_reg | (opc_reg == OP_RDPD));
    assign wel_ok = exec_ok & wel_reg;

    // ------------------------------------------------------------
    // Target range of the operation
    // ------------------------------------------------------------
    logic [ADDR_W-1:0] op_lo, op_hi;

    // Page, sector, half block, block or whole chip
    always_comb begin
        op_lo = addr_reg;
        op_hi = addr_reg;
        if (is_ce) begin
            op_lo = '0;
            op_hi = '1;
        end else if (opc_reg == OP_PP) begin
            op_lo = {addr_reg[23:PAGE_SH], 8'h00};
            op_hi = {addr_reg[23:PAGE_SH], 8'hff};
        end else if (opc_reg == OP_SE) begin
            op_lo = {addr_reg[23:SECTOR_SH], 12'h000};
            op_hi = {addr_reg[23:SECTOR_SH], 12'hfff};
        end else if (opc_reg == OP_BE32) begin
            op_lo = {addr_reg[23:BLK32_SH], 15'h0000};
            op_hi = {addr_reg[23:BLK32_SH], 15'h7fff};
        end else if (opc_reg == OP_BE64) begin
            op_lo = {addr_reg[23:BLK64_SH], 16'h0000};
            op_hi = {addr_reg[23:BLK64_SH], 16'hffff};
        end
    end

    // ------------------------------------------------------------
    // Protect field decode
    // ------------------------------------------------------------
    logic [4:0] bp;
    logic [2:0] bp_low;
    logic cmp, per_block_lock_select;
    logic [4:0] bp_sh;
    logic [ADDR_W:0] bp_mask;
    logic bp_valid, pr_valid, bp_hit, lock_hit, prot_hit;
    logic [ADDR_W-1:0] bp_lo, bp_hi, pr_lo, pr_hi;
    logic [15:0] status_reg;

    assign bp = status_reg[ST_BP_LSB +: 5];
    assign bp_low = bp[2:0];
    assign cmp = status_reg[ST_CMP_BIT];
    assign per_block_lock_select = status_reg[ST_WPS_BIT];
    // Fine steps top out at 32KB, coarse steps start at 256KB
    assign bp_sh = bp[4] ? ((bp_low >= BP_SMALL_CAP) ? BP_SMALL_MAX
                                : BP_SMALL_BASE + {2'h0, bp_low})
                         : BP_BIG_BASE + {2'h0, bp_low};
    assign bp_mask = (25'h1 << bp_sh) - 25'h1;
    assign bp_valid = (bp_low != BP_NONE);
    assign bp_lo = (bp_low == BP_ALL) | bp[3] ? '0 : ~bp_mask[ADDR_W-1:0];
    assign bp_hi = (bp_low == BP_ALL) | ~bp[3] ? '1 : bp_mask[ADDR_W-1:0];

    // Complement protects what the plain code leaves open
    always_comb begin
        pr_valid = bp_valid;
        pr_lo = bp_lo;
        pr_hi = bp_hi;
        if (cmp) begin
            pr_valid = (bp_low != BP_ALL);
            if (!bp_valid) begin
                pr_lo = '0;
                pr_hi = '1;
            end else if (bp[3]) begin
                pr_lo = bp_hi + 24'h1;
                pr_hi = '1;
            end else begin
                pr_lo = '0;
                pr_hi = bp_lo - 24'h1;
            end
        end
    end

    assign bp_hit = pr_valid & ~((op_hi < pr_lo) | (op_lo > pr_hi));

    // ------------------------------------------------------------
    // Individual lock bits
    // ------------------------------------------------------------
    logic [LOCK_N-1:0] lock_reg, lock_ovl;
    logic [8:0] addr_idx;

    // Sectors of bottom block, sectors of top block, then blocks 1..254
    function automatic logic [8:0] lock_idx(input logic [ADDR_W-1:0] a);
        if (a[23:16] == BOTTOM_BLOCK) begin
            lock_idx = {5'h00, a[15:12]};
        end else if (a[23:16] == TOP_BLOCK) begin
            lock_idx = TOP_LOCK_BASE + {5'h00, a[15:12]};
        end else begin
            lock_idx = MID_LOCK_OFS + {1'b0, a[23:16]};
        end
    endfunction

    assign addr_idx = lock_idx(addr_reg);

    // Each lock bit covers a fixed span; flag spans the op touches
    generate
        for (g = 0; g < LOCK_N; g++) begin : g_lock
            localparam logic [ADDR_W-1:0] LS = (g < 16) ? 24'(g * 4096)
                : (g < 32) ? 24'(16711680 + (g - 16) * 4096)
                : 24'((g - 31) * 65536);
            localparam logic [ADDR_W-1:0] LE = LS + ((g < 32) ? 24'h000fff : 24'h00ffff);
            assign lock_ovl[g] = ~((op_hi < LS) | (op_lo > LE));
        end
    endgenerate

    assign lock_hit = |(lock_reg & lock_ovl);
    assign prot_hit = per_block_lock_select ? lock_hit : bp_hit;
    assign do_write = wel_ok & is_ep & ~prot_hit;

    // ------------------------------------------------------------
    // Protection state updates
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wel_reg <= 1'b0;
            dpd_reg <= 1'b0;
            status_reg <= STATUS_RST;
            lock_reg <= '1;
        end else begin
            if (exec_ok & (opc_reg == OP_WRITE_ENABLE_COMMAND)) wel_reg <= 1'b1;
            else if (exec_ok & (opc_reg == OP_WRDI)) wel_reg <= 1'b0;
            else if (wel_ok & is_wcls) wel_reg <= 1'b0;
            if (exec_ok & (opc_reg == OP_DPD)) dpd_reg <= 1'b1;
            else if (exec_ok & (opc_reg == OP_RDPD)) dpd_reg <= 1'b0;
            if (wel_ok & (opc_reg == OP_WRSR)) begin
                status_reg[ST_CMP_BIT] <= st1_reg[ST_CMP_BIT - 8];
                status_reg[ST_WPS_BIT] <= st1_reg[ST_WPS_BIT - 8];
                if (wp_lvl) begin
                    status_reg[ST_BP_LSB +: 5] <= st0_reg[ST_BP_LSB +: 5];
                    status_reg[ST_SRP0_BIT] <= st0_reg[ST_SRP0_BIT];
                    status_reg[ST_SRP1_BIT] <= st1_reg[ST_SRP1_BIT - 8];
                end
            end
            if (wel_ok & (opc_reg == OP_LOCK)) lock_reg[addr_idx] <= 1'b1;
            if (wel_ok & (opc_reg == OP_UNLOCK)) lock_reg[addr_idx] <= 1'b0;
            if (wel_ok & (opc_reg == OP_GLOCK)) lock_reg <= '1;
            if (wel_ok & (opc_reg == OP_GUNLOCK)) lock_reg <= '0;
        end
    end

    // ------------------------------------------------------------
    // Verdict, lock readback and APB
    // ------------------------------------------------------------
    logic grant_reg, reject_reg, so_reg, so_oe_reg;
    logic [7:0] op_code_reg;
    logic [ADDR_W-1:0] op_addr_reg;
    logic apb_wr, apb_setup, mapped;
    logic [31:0] rd_word, prdata_reg;

    // One verdict pulse per erase or program command
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            grant_reg <= 1'b0;
            reject_reg <= 1'b0;
            op_code_reg <= 8'h00;
            op_addr_reg <= '0;
            so_reg <= 1'b0;
            so_oe_reg <= 1'b0;
        end else begin
            grant_reg <= do_write;
            reject_reg <= exec & is_ep & ~do_write;
            if (exec & is_ep) op_code_reg <= opc_reg;
            if (exec & is_ep) op_addr_reg <= addr_reg;
            so_reg <= lock_reg[addr_idx];
            so_oe_reg <= (state_reg == ST_FRAME) & cs_act & ~dpd_reg
                       & (opc_reg == OP_RDLOCK) & (byte_cnt_reg >= 3'h4);
        end
    end

    assign apb_wr = psel & penable & pwrite;
    assign apb_setup = psel & ~penable;
    assign mapped = (paddr == REG_STATUS) | (paddr == REG_CTRL)
                  | (paddr == REG_VERDICT) | (paddr == REG_OP_ADDR)
                  | (paddr == REG_FILL);
    assign rd_word = (paddr == REG_STATUS) ? {15'h0000, dpd_reg, status_reg[15:2],
                                              wel_reg, 1'b0}
                   : (paddr == REG_CTRL) ? ctrl_reg
                   : (paddr == REG_VERDICT) ? {22'h000000, reject_reg, grant_reg,
                                               op_code_reg}
                   : (paddr == REG_OP_ADDR) ? {8'h00, op_addr_reg}
                   : (paddr == REG_FILL) ? {24'h000000, ERASED_BYTE}
                   : 32'h0000_0000;

    // Read data captured in setup so the access phase needs no wait
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= CTRL_RST;
            prdata_reg <= 32'h0000_0000;
        end else begin
            if (apb_wr & (paddr == REG_CTRL)) ctrl_reg <= {31'h0, pwdata[0]};
            if (apb_setup) prdata_reg <= rd_word;
        end
    end

    assign prdata = prdata_reg;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign so_o = so_reg;
    assign so_oe = so_oe_reg;
    assign grant = grant_reg;
    assign reject = reject_reg;
    assign op_code = op_code_reg;
    assign op_addr = op_addr_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_exec_cmd(logic [7:0] c);
        exec_ok && wel_reg && opc_reg == c;
    endsequence

    sequence s_ragged_end;
        cs_rise && state_reg == ST_FRAME && bit_cnt_reg != 3'h0;
    endsequence

    property p_wel_needed;
        @(posedge pclk) disable iff (!presetn) grant |-> $past(wel_reg);
    endproperty
    a_wel_needed: assert property (p_wel_needed) else $error("grant without latch");

    property p_write_enable_command_sets;
        @(posedge pclk) disable iff (!presetn)
            (exec_ok && opc_reg == OP_WRITE_ENABLE_COMMAND) |=> wel_reg;
    endproperty
    a_write_enable_command_sets: assert property (p_write_enable_command_sets) else $error("latch not set");

    property p_wp_freeze;
        @(posedge pclk) disable iff (!presetn)
            !wp_lvl |=> $stable(status_reg[ST_SRP1_BIT:ST_BP_LSB]);
    endproperty
    a_wp_freeze: assert property (p_wp_freeze) else $error("protect bits moved");

    property p_dpd_quiet;
        @(posedge pclk) disable iff (!presetn) dpd_reg |=> !grant;
    endproperty
    a_dpd_quiet: assert property (p_dpd_quiet) else $error("write in power-down");

    property p_ragged;
        @(posedge pclk) disable iff (!presetn) s_ragged_end |-> ##2 !grant;
    endproperty
    a_ragged: assert property (p_ragged) else $error("ragged frame granted");

    property p_prot_drop;
        @(posedge pclk) disable iff (!presetn)
            (exec && is_ep && prot_hit) |=> !grant && reject;
    endproperty
    a_prot_drop: assert property (p_prot_drop) else $error("protected op passed");

    property p_half_top;
        @(posedge pclk) disable iff (!presetn)
            (bp == 5'h06 && !cmp) |-> pr_valid && pr_lo == 24'h800000 && pr_hi == '1;
    endproperty
    a_half_top: assert property (p_half_top) else $error("8MB top range wrong");

    property p_fine_low;
        @(posedge pclk) disable iff (!presetn)
            (bp == 5'h19 && !cmp) |-> pr_lo == '0 && pr_hi == 24'h000fff;
    endproperty
    a_fine_low: assert property (p_fine_low) else $error("4KB bottom range wrong");

    property p_cmp_all;
        @(posedge pclk) disable iff (!presetn)
            (cmp && bp_low == BP_NONE) |-> pr_valid && pr_lo == '0 && pr_hi == '1;
    endproperty
    a_cmp_all: assert property (p_cmp_all) else $error("complement not all");

    property p_mode_sel;
        @(posedge pclk) disable iff (!presetn)
            (wel_ok && is_ep && !per_block_lock_select && !bp_hit) |=> grant;
    endproperty
    a_mode_sel: assert property (p_mode_sel) else $error("locks used outside mode");

    property p_lock_set;
        @(posedge pclk) disable iff (!presetn)
            s_exec_cmd(OP_LOCK) |=> lock_reg[$past(addr_idx)];
    endproperty
    a_lock_set: assert property (p_lock_set) else $error("lock bit not set");

    property p_gunlock;
        @(posedge pclk) disable iff (!presetn)
            s_exec_cmd(OP_GUNLOCK) |=> lock_reg == '0;
    endproperty
    a_gunlock: assert property (p_gunlock) else $error("global unlock failed");

endmodule

// ### verif/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
    // Link pins
    output logic sclk,
    output logic cs_n,
    output logic si
);
    // Idle link: clock still, device deselected
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
    end
    // Send n bits MSB first, mode 0, 160 ns link period
    task automatic frame(input logic [39:0] d, input int n);
        cs_n <= 1'b0;
        for (int i = 0; i < n; i++) begin
            si <= d[39-i];
            #80 sclk <= 1'b1;
            #80 sclk <= 1'b0;
        end
        #80 cs_n <= 1'b1;
        si <= ~si; // Released line shows no stale bit
    endtask
endmodule

// ### verif/serial_flash_write_protection_tb_top.sv
`timescale 1ns/1ps
module serial_flash_write_protection_tb_top;
    import flash_prot_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, wp_n = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, sclk, cs_n, si, grant, reject, so_o, so_oe, so_seen;
    logic [7:0] op_code;
    logic [23:0] op_addr;
    int errors = 0, tests_run = 0, cycles = 0, grants = 0, rejects = 0, g0 = 0, r0 = 0;
    // Clock
    always #4 pclk = ~pclk;
    spi_host_model i_host (.sclk(sclk), .cs_n(cs_n), .si(si));
    flash_write_protect i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sclk(sclk), .cs_n(cs_n), .si(si), .wp_n(wp_n), .so_o(so_o),
        .so_oe(so_oe), .grant(grant), .reject(reject), .op_code(op_code), .op_addr(op_addr));
    // APB transfer, result kept at the pready edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd & m, exp);
    endtask
    task automatic send(input logic [39:0] d, input int n);
        i_host.frame(d, n);
        repeat (12) @(posedge pclk);
    endtask
    task automatic cmd(input logic [7:0] op, input logic [23:0] a);
        send({OP_WRITE_ENABLE_COMMAND, 32'h0}, 8);
        send({op, a, 8'h00}, 32);
    endtask
    // Verdict pulses seen since the previous check: one grant or one reject
    task automatic vchk(input logic ok);
        chk((grants - g0) * 2 + (rejects - r0), {30'h0, ok, ~ok});
        g0 = grants;
        r0 = rejects;
    endtask
    task automatic erase(input logic [23:0] a, input logic ok);
        cmd(OP_SE, a);
        vchk(ok);
        chk({8'h0, op_addr}, {8'h0, a});
        rchk(REG_VERDICT, 32'h3ff, {24'h0, OP_SE});
    endtask
    task automatic wrsr(input logic [7:0] s0, input logic [7:0] s1);
        send({OP_WRITE_ENABLE_COMMAND, 32'h0}, 8);
        send({OP_WRSR, s0, s1, 16'h0}, 24);
    endtask
    task automatic wrap_up();
        if (errors == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Hang guard, verdict pulse counts and lock readback
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        grants <= grants + grant;
        rejects <= rejects + reject;
        if (so_oe) so_seen <= so_o;
        if (cycles == 80000) begin
            errors++;
            wrap_up();
        end
    end
    // Main sequence
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (8) @(posedge pclk);
        rchk(REG_STATUS, 32'hffff_ffff, 32'h0);
        rchk(REG_FILL, 32'hff, {24'h0, ERASED_BYTE});
        apb(1'b0, 8'h20, 32'h0);
        chk({31'h0, err}, 32'h1);
        send({OP_SE, 32'h0}, 32);
        vchk(1'b0);
        send({OP_WRITE_ENABLE_COMMAND, 32'h0}, 7);
        rchk(REG_STATUS, 32'h2, 32'h0);
        erase(24'h000000, 1'b1);
        wrsr(8'h04, 8'h00);
        erase(24'hfc0000, 1'b0);
        erase(24'hfbf000, 1'b1);
        wrsr(8'h18, 8'h00);
        erase(24'h800000, 1'b0);
        erase(24'h7ff000, 1'b1);
        wrsr(8'h44, 8'h00);
        erase(24'hfff000, 1'b0);
        erase(24'hffe000, 1'b1);
        wrsr(8'h64, 8'h00);
        erase(24'h000000, 1'b0);
        erase(24'h001000, 1'b1);
        wrsr(8'h04, 8'h40);
        erase(24'hfc0000, 1'b1);
        erase(24'hfbf000, 1'b0);
        wrsr(8'h00, 8'h44);
        erase(24'h010000, 1'b0);
        cmd(OP_UNLOCK, 24'h000000);
        erase(24'h000000, 1'b1);
        erase(24'h001000, 1'b0);
        send({OP_RDLOCK, 32'h0}, 40);
        chk({31'h0, so_seen}, 32'h0);
        send({OP_RDLOCK, 24'h001000, 8'h00}, 40);
        chk({31'h0, so_seen}, 32'h1);
        send({OP_WRITE_ENABLE_COMMAND, 32'h0}, 8);
        send({OP_GUNLOCK, 32'h0}, 8);
        erase(24'h030000, 1'b1);
        send({OP_WRITE_ENABLE_COMMAND, 32'h0}, 8);
        send({OP_CE2, 32'h0}, 8);
        vchk(1'b1);
        cmd(OP_LOCK, 24'h030000);
        erase(24'h030000, 1'b0);
        erase(24'h040000, 1'b1);
        send({OP_WRITE_ENABLE_COMMAND, 32'h0}, 8);
        send({OP_GLOCK, 32'h0}, 8);
        erase(24'h040000, 1'b0);
        wp_n <= 1'b0;
        wrsr(8'h08, 8'h04);
        rchk(REG_STATUS, 32'h447c, 32'h400);
        wp_n <= 1'b1;
        send({OP_DPD, 32'h0}, 8);
        send({OP_WRITE_ENABLE_COMMAND, 32'h0}, 8);
        rchk(REG_STATUS, 32'h10002, 32'h10000);
        send({OP_RDPD, 32'h0}, 8);
        send({OP_WRITE_ENABLE_COMMAND, 32'h0}, 8);
        rchk(REG_STATUS, 32'h10002, 32'h2);
        wrap_up();
    end
endmodule
